/* design/bsl_loader.v */
/*
  reset-time boot sequencer: straps, pll preset, image load from spi
  flash, link b or otp, crc check and jump.
  assumes straps and link pins are asynchronous; otp and ram are
  synchronous memories on clk_i with one-cycle read latency for otp.
*/
`default_nettype none
// What this block does
// - while chip reset is low, all general-purpose pins stay undriven
// - after release, run 15 us reset phase, then pull-ups on and boot
// - low straps pick pll divider and feedback presets; input divider preset is fixed
// - tile clock from oscillator by pll formula, settings within ranges
// - high straps pick boot source: test port, reserved, link, spi
// - secure-boot bit forces boot from otp address zero
// - image is count word, count times four bytes, checksum, lsb first
// - checksum word of magic value skips the crc check
// - program written from lowest ram address, executed from there
// - reflected crc-32, preset all ones, residue inverted for compare
// - crc covers count word and program bytes, not checksum
// - spi master on fixed pins, serial clock at slow fixed rate
// - spi boot sends read command and address zero, then streams
// - spi clock idles low, data sampled on rising edge
// - spi data bytes shift in least significant bit first; command shifts out msb first
// - spi pins fixed, not configurable
// - link boot enables link b 200 ns in, drives outputs low
// - link boot: chanend 0, ack dest, image, end token, send end
// - security register loaded from otp before source is chosen
module bsl_loader (
  input  wire        clk_i,
  input  wire        rstn_i,
  input  wire        pll_strap_low_i,
  input  wire        pll_strap_high_i,
  input  wire [1:0]  src_strap_i,
  input  wire [31:0] sec_reg_i,
  output reg         sec_rd_o,
  output reg  [8:0]  otp_addr_o,
  input  wire [31:0] otp_data_i,
  input  wire        spi_miso_i,
  output reg         spi_ss_n_o,
  output reg         spi_sclk_o,
  output reg         spi_mosi_o,
  output reg         spi_oe_o,
  input  wire [1:0]  link_in_i,
  output reg  [1:0]  link_out_o,
  output reg         link_oe_o,
  output reg         link_pd_off_o,
  input  wire        link_byte_vld_i,
  input  wire [7:0]  link_byte_i,
  input  wire        link_end_i,
  output reg         link_end_o,
  output reg  [31:0] ack_dest_o,
  output reg         chanend_alloc_o,
  output reg         gpio_oe_o,
  output reg         pull_en_o,
  output reg  [2:0]  pll_output_divider_o,
  output reg  [11:0] pll_feedback_o,
  output reg  [5:0]  pll_in_div_o,
  output reg         ram_we_o,
  output reg  [13:0] ram_addr_o,
  output reg  [31:0] ram_wdata_o,
  output reg         jump_o,
  output reg  [13:0] jump_addr_o,
  output reg         crc_err_o
);
  `include "bsl_regs.vh"
  // ----------------------------------------------------------------------
  // states
  // ----------------------------------------------------------------------
  localparam [3:0] ST_RST   = 4'h0;
  localparam [3:0] ST_SEC   = 4'h1;
  localparam [3:0] ST_PICK  = 4'h2;
  localparam [3:0] ST_WAIT  = 4'h3;
  localparam [3:0] ST_SPICM = 4'h4;
  localparam [3:0] ST_LOAD  = 4'h5;
  localparam [3:0] ST_LKEN  = 4'h6;
  localparam [3:0] ST_LKACK = 4'h7;
  localparam [3:0] ST_LKEND = 4'h8;
  localparam [3:0] ST_CHECK = 4'h9;
  localparam [3:0] ST_RUN   = 4'hA;
  localparam [3:0] ST_IDLE  = 4'hB;
  localparam [3:0] ST_OTP   = 4'hC;
  localparam [1:0] SRC_OTP  = 2'h1;
  localparam [15:0] RST_CYC  = `BSL_RST_CYC;
  localparam [15:0] LINK_CYC = `BSL_LINK_EN_CYC;
  localparam [7:0]  HALF_CYC = `BSL_SPI_HALF_CYC;

  // ----------------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------------
  reg [4:0] sa_q;
  reg [4:0] sb_q;
  always @(posedge clk_i) begin
    sa_q <= {spi_miso_i, src_strap_i, pll_strap_high_i, pll_strap_low_i};
    sb_q <= sa_q;
  end
  reg [1:0] la_q;
  reg [1:0] lb_q;
  always @(posedge clk_i) begin
    la_q <= link_in_i;
    lb_q <= la_q;
  end

  reg [3:0]  st_q;
  reg [15:0] cnt_q;
  reg [1:0]  src_q;
  reg [31:0] crc_q;
  reg [31:0] word_q;
  reg [1:0]  bidx_q;
  reg [1:0]  phase_q;   // 0 count, 1 program, 2 checksum
  reg [31:0] words_q;
  reg [31:0] sh_q;      // spi command shift
  reg [5:0]  bits_q;
  reg [7:0]  rx_q;
  reg [2:0]  rxn_q;
  reg [7:0]  div_q;
  reg        otp_ph_q;
  wire [31:0] crc_nx;
  reg        byte_v;
  reg [7:0]  byte_d;

  bsl_crc8 u_crc (
    .crc_i  (crc_q),
    .byte_i (byte_d),
    .crc_o  (crc_nx)
  );

  // ----------------------------------------------------------------------
  // spi clock divider: one-cycle half-period tick
  // ----------------------------------------------------------------------
  wire tick = (div_q == HALF_CYC - 8'h01);
  always @(posedge clk_i) begin
    if (!rstn_i || spi_ss_n_o) begin
      div_q <= 8'h00;
    end else if (tick) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  // ----------------------------------------------------------------------
  // byte source select for the image parser
  // ----------------------------------------------------------------------
  always @* begin
    byte_v = 1'b0;
    byte_d = 8'h00;
    if (st_q == ST_LOAD) begin
      if (src_q == `BSL_SRC_SPI && tick && !spi_sclk_o &&
          rxn_q == 3'h7 && bits_q == 6'h00) begin
        byte_v = 1'b1;
        byte_d = {sb_q[4], rx_q[7:1]};
      end else if (src_q == `BSL_SRC_LINK && link_byte_vld_i) begin
        byte_v = 1'b1;
        byte_d = link_byte_i;
      end else if (src_q == SRC_OTP && otp_ph_q) begin
        byte_v = 1'b1;
        byte_d = otp_data_i[{bidx_q, 3'h0} +: 8];
      end
    end
  end

  // ----------------------------------------------------------------------
  // main sequencer
  // ----------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      st_q <= ST_RST; cnt_q <= 16'h0000; src_q <= `BSL_SRC_NONE;
      crc_q <= `BSL_CRC_INIT; word_q <= 32'h0000_0000;
      bidx_q <= 2'h0; phase_q <= 2'h0; words_q <= 32'h0000_0000;
      sh_q <= 32'h0000_0000; bits_q <= 6'h00; rx_q <= 8'h00;
      rxn_q <= 3'h0; otp_ph_q <= 1'b0;
      sec_rd_o <= 1'b0; otp_addr_o <= 9'h000;
      spi_ss_n_o <= 1'b1; spi_sclk_o <= 1'b0; spi_mosi_o <= 1'b0;
      spi_oe_o <= 1'b0; link_out_o <= 2'h0; link_oe_o <= 1'b0;
      link_pd_off_o <= 1'b0; link_end_o <= 1'b0;
      ack_dest_o <= 32'h0000_0000; chanend_alloc_o <= 1'b0;
      gpio_oe_o <= 1'b0;
      pull_en_o <= 1'b0;
      pll_output_divider_o <= `BSL_PLL_OD_00;
      pll_feedback_o <= `BSL_PLL_F_00; pll_in_div_o <= `BSL_PLL_R;
      ram_we_o <= 1'b0; ram_addr_o <= `BSL_RAM_BASE;
      ram_wdata_o <= 32'h0000_0000; jump_o <= 1'b0;
      jump_addr_o <= `BSL_RAM_BASE; crc_err_o <= 1'b0;
    end else begin
      ram_we_o <= 1'b0;
      link_end_o <= 1'b0;
      sec_rd_o <= 1'b0;
      case (st_q)
        ST_RST: begin
          cnt_q <= cnt_q + 16'h0001;
          if (cnt_q == RST_CYC - 16'h0001) begin
            pull_en_o <= 1'b1;
            gpio_oe_o <= 1'b1;
            sec_rd_o <= 1'b1;
            st_q <= ST_SEC;
            // straps static since reset, sampled here
            case ({sb_q[1], sb_q[0]})
              2'b00: begin
                pll_output_divider_o <= `BSL_PLL_OD_00;
                pll_feedback_o <= `BSL_PLL_F_00;
              end
              2'b11: begin
                pll_output_divider_o <= `BSL_PLL_OD_X;
                pll_feedback_o <= `BSL_PLL_F_11;
              end
              2'b10: begin
                pll_output_divider_o <= `BSL_PLL_OD_X;
                pll_feedback_o <= `BSL_PLL_F_10;
              end
              default: begin
                pll_output_divider_o <= `BSL_PLL_OD_X;
                pll_feedback_o <= `BSL_PLL_F_01;
              end
            endcase
            pll_in_div_o <= `BSL_PLL_R;
          end
        end
        ST_SEC: st_q <= ST_PICK;                 // otp security load
        ST_PICK: begin
          cnt_q <= 16'h0000;
          crc_q <= `BSL_CRC_INIT;
          phase_q <= 2'h0; bidx_q <= 2'h0;
          ram_addr_o <= `BSL_RAM_BASE;
          if (sec_reg_i[`BSL_SEC_BOOT_BIT]) begin
            src_q <= SRC_OTP;
            otp_addr_o <= 9'h000;
            st_q <= ST_OTP;
          end else begin
            src_q <= sb_q[3:2];
            case (sb_q[3:2])
              `BSL_SRC_SPI: begin
                spi_oe_o <= 1'b1;
                spi_ss_n_o <= 1'b0;
                sh_q <= {`BSL_SPI_READ_CMD, `BSL_SPI_ADDR};
                bits_q <= 6'h20;
                st_q <= ST_SPICM;
              end
              `BSL_SRC_LINK: st_q <= ST_LKEN;
              default: st_q <= ST_WAIT;
            endcase
          end
        end
        ST_WAIT: st_q <= ST_WAIT;                // test port loads
        ST_OTP: begin
          otp_ph_q <= 1'b1;
          st_q <= ST_LOAD;
        end
        ST_SPICM, ST_LOAD: begin
          if (src_q == `BSL_SRC_SPI && tick) begin
            spi_sclk_o <= ~spi_sclk_o;
            if (spi_sclk_o) begin                // falling: next out bit
              if (bits_q != 6'h00) begin
                spi_mosi_o <= sh_q[31];
                sh_q <= {sh_q[30:0], 1'b0};
                bits_q <= bits_q - 6'h01;
              end
            end else if (bits_q == 6'h00 && st_q == ST_LOAD) begin
              rx_q <= {sb_q[4], rx_q[7:1]};
              rxn_q <= rxn_q + 3'h1;
            end
            if (st_q == ST_SPICM && bits_q == 6'h00 && spi_sclk_o) begin
              st_q <= ST_LOAD;
              rxn_q <= 3'h0;
            end
          end
          if (st_q == ST_SPICM && bits_q == 6'h20 && !tick) begin
            spi_mosi_o <= sh_q[31];
            sh_q <= {sh_q[30:0], 1'b0};
            bits_q <= 6'h1F;
          end
          // otp word address moved: data is in one cycle later
          if (src_q == SRC_OTP && !otp_ph_q) begin
            otp_ph_q <= 1'b1;
          end
          if (byte_v) begin
            word_q <= {byte_d, word_q[31:8]};
            bidx_q <= bidx_q + 2'h1;
            if (phase_q != 2'h2) begin
              crc_q <= crc_nx;
            end
            if (src_q == SRC_OTP && bidx_q == 2'h3) begin
              otp_addr_o <= otp_addr_o + 9'h001;
              otp_ph_q <= 1'b0;                  // wait for next word
            end
            if (bidx_q == 2'h3) begin
              if (phase_q == 2'h0) begin
                words_q <= {byte_d, word_q[31:8]};
                phase_q <= ({byte_d, word_q[31:8]} == 32'h0000_0000) ?
                           2'h2 : 2'h1;
              end else if (phase_q == 2'h1) begin
                ram_we_o <= 1'b1;
                ram_wdata_o <= {byte_d, word_q[31:8]};
                words_q <= words_q - 32'h0000_0001;
                if (words_q == 32'h0000_0001) begin
                  phase_q <= 2'h2;
                end
              end else begin
                st_q <= (src_q == `BSL_SRC_LINK) ? ST_LKEND : ST_CHECK;
                spi_ss_n_o <= 1'b1;
                spi_sclk_o <= 1'b0;
                otp_ph_q <= 1'b0;
              end
            end
          end
          if (ram_we_o) begin
            ram_addr_o <= ram_addr_o + 14'h0001;
          end
        end
        ST_LKEN: begin
          cnt_q <= cnt_q + 16'h0001;
          if (cnt_q == LINK_CYC - 16'h0001) begin
            link_pd_off_o <= 1'b1;
            link_oe_o <= 1'b1;
            link_out_o <= 2'h0;
            chanend_alloc_o <= 1'b1;
            bidx_q <= 2'h0;
            st_q <= ST_LKACK;
          end
        end
        ST_LKACK: begin                          // ack destination word
          if (link_byte_vld_i) begin
            word_q <= {link_byte_i, word_q[31:8]};
            bidx_q <= bidx_q + 2'h1;
            if (bidx_q == 2'h3) begin
              ack_dest_o <= {link_byte_i, word_q[31:8]};
              st_q <= ST_LOAD;
            end
          end
        end
        ST_LKEND: begin
          if (link_end_i) begin
            link_end_o <= 1'b1;
            chanend_alloc_o <= 1'b0;
            st_q <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          if (word_q == `BSL_NO_CRC ||
              word_q == ~crc_q) begin
            jump_o <= 1'b1;
            jump_addr_o <= `BSL_RAM_BASE;
            st_q <= ST_RUN;
          end else begin
            crc_err_o <= 1'b1;
            st_q <= ST_IDLE;
          end
        end
        ST_RUN: st_q <= ST_RUN;
        ST_IDLE: st_q <= ST_IDLE;
        default: st_q <= ST_RST;
      endcase
    end
  end
endmodule // bsl_loader
`default_nettype wire

/* design/bsl_regs.vh */
/*
  constants of the reset-time boot loader: strap codes, pll settings,
  image format, crc, spi and link timing.
  assumes a 50 MHz core clock.
*/
`ifndef BSL_REGS_VH
`define BSL_REGS_VH
// ----------------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------------
`define BSL_CLK_MHZ        50
`define BSL_RST_PHASE_US   15
`define BSL_RST_CYC        16'h02EE  // 15 us at 50 MHz
`define BSL_LINK_EN_NS     200
`define BSL_LINK_EN_CYC    16'h000A  // 200 ns at 50 MHz
`define BSL_SPI_KHZ        2500
`define BSL_SPI_HALF_CYC   8'h0A     // 2.5 MHz serial clock at 50 MHz
// ----------------------------------------------------------------------
// pll settings per strap pair {high,low}
// ----------------------------------------------------------------------
`define BSL_PLL_OD_00      3'h1
`define BSL_PLL_F_00       12'h07A
`define BSL_PLL_OD_X       3'h2
`define BSL_PLL_F_11       12'h077
`define BSL_PLL_F_10       12'h031
`define BSL_PLL_F_01       12'h017
`define BSL_PLL_R          6'h00
// ----------------------------------------------------------------------
// boot sources, image, crc, link
// ----------------------------------------------------------------------
`define BSL_SRC_NONE       2'h0
`define BSL_SRC_RSVD       2'h1
`define BSL_SRC_LINK       2'h2
`define BSL_SRC_SPI        2'h3
`define BSL_SEC_BOOT_BIT   5
`define BSL_NO_CRC         32'h0D15_AB1E
`define BSL_CRC_POLY       32'hEDB8_8320
`define BSL_CRC_INIT       32'hFFFF_FFFF
`define BSL_SPI_READ_CMD   8'h03
`define BSL_SPI_ADDR       24'h00_0000
`define BSL_CHANEND_0      8'h00
`define BSL_RAM_BASE       14'h0000
`endif

/* design/bsl_crc8.v */
/*
  one byte step of a reflected crc-32.
  assumes the caller holds the register and presets it.
*/
`default_nettype none
module bsl_crc8 (
  input  wire [31:0] crc_i,
  input  wire [7:0]  byte_i,
  output reg  [31:0] crc_o
);
  `include "bsl_regs.vh"
  integer k;
  // ----------------------------------------------------------------------
  // eight bit steps, lsb first
  // ----------------------------------------------------------------------
  always @* begin
    crc_o = crc_i ^ {24'h00_0000, byte_i};
    for (k = 0; k < 8; k = k + 1) begin
      if (crc_o[0]) begin
        crc_o = (crc_o >> 1) ^ `BSL_CRC_POLY;
      end else begin
        crc_o = crc_o >> 1;
      end
    end
  end
endmodule // bsl_crc8
`default_nettype wire

/* test/bsl_loader_checker.sv */
/*
  port assertions of the boot loader.
  assumes it is bound into the loader and sees one clock domain.
*/
`default_nettype none
module bsl_loader_checker (
  input wire logic        clk_i,
  input wire logic        rstn_i,
  input wire logic [1:0]  src_strap_i,
  input wire logic [31:0] sec_reg_i,
  input wire logic        sec_rd_o,
  input wire logic        spi_ss_n_o,
  input wire logic        spi_sclk_o,
  input wire logic        spi_mosi_o,
  input wire logic        spi_oe_o,
  input wire logic [1:0]  link_out_o,
  input wire logic        link_oe_o,
  input wire logic        link_pd_off_o,
  input wire logic        link_end_o,
  input wire logic        gpio_oe_o,
  input wire logic        pull_en_o,
  input wire logic        ram_we_o,
  input wire logic [13:0] ram_addr_o,
  input wire logic        jump_o,
  input wire logic [13:0] jump_addr_o,
  input wire logic        crc_err_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------------------------------------------------
  // cycles since reset release, saturating
  // --------------------------------------------------------------
  logic [9:0] cnt_q;
  always_ff @(posedge clk_i) begin
    if (!rstn_i) cnt_q <= 10'h000;
    else if (cnt_q != 10'h3FF) cnt_q <= cnt_q + 10'h001;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // --------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------
  a_reset_quiet: assert property (disable iff (1'b0)
    !rstn_i |=> !gpio_oe_o && !spi_oe_o && !link_oe_o && !pull_en_o)
    else $error("pins driven during reset");
  a_reset_phase: assert property ($rose(pull_en_o) |->
    cnt_q >= 10'h2E9 && cnt_q <= 10'h2F8)
    else $error("reset phase length wrong");
  a_sclk_idle: assert property (spi_ss_n_o |-> !spi_sclk_o)
    else $error("serial clock not idle low");
  a_sclk_half: assert property ($rose(spi_sclk_o) |->
    spi_sclk_o[*8] ##1 spi_sclk_o[*2] ##1 !spi_sclk_o)
    else $error("serial clock high phase not 10 cycles");
  a_mosi_hold: assert property ($rose(spi_sclk_o) |->
    $stable(spi_mosi_o))
    else $error("mosi moved on rising clock");
  a_link_idle: assert property (link_oe_o |->
    link_out_o == 2'b00 && link_pd_off_o)
    else $error("link outputs not low");
  a_jump_base: assert property (jump_o |->
    jump_addr_o == 14'h0000 && !crc_err_o)
    else $error("jump bad address or after crc error");
  a_ram_step: assert property (ram_we_o |=>
    ram_addr_o == $past(ram_addr_o) + 14'h0001)
    else $error("ram address did not step");
  a_secure_otp: assert property (sec_reg_i[5] |->
    !spi_oe_o && !link_oe_o)
    else $error("external source used in secure boot");
  a_no_source: assert property (!sec_reg_i[5] && !src_strap_i[1] |->
    !spi_oe_o && !link_oe_o && !jump_o)
    else $error("boot without a source");
  a_sec_first: assert property ($rose(pull_en_o) |->
    sec_rd_o && !spi_oe_o && !link_oe_o ##1 !sec_rd_o)
    else $error("security load not ahead of boot source");
  c_jump: cover property (jump_o);
  c_crc_err: cover property (crc_err_o);
  c_link_end: cover property (link_end_o);
endmodule // bsl_loader_checker
`default_nettype wire

/* test/bsl_flash_model.sv */
/*
  serial flash stand-in: takes 32 command bits, then streams img
  bytes lsb first. assumes mode 0 clocking from the loader.
*/
`default_nettype none
module bsl_flash_model (
  input  wire logic clk_i,
  input  wire logic ss_n_i,
  input  wire logic sclk_i,
  input  wire logic mosi_i,
  output var  logic miso_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------------------------------------------------
  // command capture and data stream
  // --------------------------------------------------------------
  logic [7:0]  img [0:63];
  logic [31:0] cmd_q = 32'h0000_0000;
  int          bitn = 0;
  // command bits in on rising clock
  always @(posedge sclk_i or posedge ss_n_i) begin
    if (ss_n_i) bitn <= 0;
    else begin
      if (bitn < 32) cmd_q <= {cmd_q[30:0], mosi_i};
      bitn <= bitn + 1;
    end
  end
  // data on falling clock; released line toggles every cycle
  always @(negedge sclk_i or posedge clk_i) begin
    if (ss_n_i) miso_o <= (miso_o === 1'b1) ? 1'b0 : 1'b1;
    else if (!sclk_i && bitn >= 32)
      miso_o <= img[(bitn - 32) / 8][(bitn - 32) % 8];
  end
endmodule // bsl_flash_model
`default_nettype wire

/* test/tb_top.sv */
/*
  self-checking bench of the boot loader: spi, link, otp, idle boots.
  assumes a 50 MHz clock and the flash model on the spi pins.
*/
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i, rstn_i, pll_strap_low_i, pll_strap_high_i;
  logic [1:0]  src_strap_i, link_in_i, link_out_o;
  logic [31:0] sec_reg_i, otp_data_i, ack_dest_o, ram_wdata_o;
  logic        sec_rd_o, spi_miso_i, spi_ss_n_o, spi_sclk_o, spi_mosi_o;
  logic        spi_oe_o, link_oe_o, link_pd_off_o, link_byte_vld_i;
  logic        link_end_i, link_end_o, chanend_alloc_o, gpio_oe_o;
  logic        pull_en_o, ram_we_o, jump_o, crc_err_o;
  logic [7:0]  link_byte_i;
  logic [8:0]  otp_addr_o;
  logic [2:0]  pll_output_divider_o;
  logic [11:0] pll_feedback_o;
  logic [5:0]  pll_in_div_o;
  logic [13:0] ram_addr_o, jump_addr_o;
  logic [31:0] otp_mem [0:15];
  logic [45:0] wq [$];
  logic [7:0]  img_q [$];
  int          fails, compares, cyc;
  bsl_loader dut_u (.*);
  bsl_flash_model fl_u (
    .clk_i  (clk_i),
    .ss_n_i (spi_ss_n_o),
    .sclk_i (spi_sclk_o),
    .mosi_i (spi_mosi_o),
    .miso_o (spi_miso_i)
  );
  // --------------------------------------------------------------
  // clock, otp read, ram log, run limit
  // --------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    otp_data_i <= otp_mem[otp_addr_o[3:0]];
    if (ram_we_o === 1'b1) wq.push_back({ram_addr_o, ram_wdata_o});
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fails++;
      complete_run();
    end
  end
  // --------------------------------------------------------------
  // shared tasks
  // --------------------------------------------------------------
  task automatic complete_run;
    if (fails == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  // one byte of reflected crc
  function automatic logic [31:0] crc_step(input logic [31:0] c,
                                           input logic [7:0]  b);
    c = c ^ {24'h00_0000, b};
    for (int k = 0; k < 8; k++)
      c = c[0] ? (c >> 1) ^ 32'hEDB8_8320 : c >> 1;
    return c;
  endfunction
  // image of n words; mode 0 good, 1 bad crc, 2 skip word
  task automatic mk_img(input int n, input int mode);
    logic [31:0] c;
    logic [31:0] w;
    c = 32'hFFFF_FFFF;
    w = 32'(n);
    img_q.delete();
    for (int i = 0; i < 4 + 4 * n; i++) begin
      img_q.push_back(i < 4 ? w[8*i +: 8] : 8'(i * 37 + 5));
      c = crc_step(c, img_q[i]);
    end
    w = (mode == 2) ? 32'h0D15_AB1E : ~c ^ 32'(mode);
    for (int i = 0; i < 4; i++) img_q.push_back(w[8*i +: 8]);
  endtask
  task automatic rst(input logic [1:0] src, pll, input logic [31:0] sec);
    @(posedge clk_i);
    rstn_i <= 1'b0;
    src_strap_i <= src;
    {pll_strap_high_i, pll_strap_low_i} <= pll;
    sec_reg_i <= sec;
    repeat (20) @(posedge clk_i);
    chk("gpio_oe_rst", 32'h0, 32'(gpio_oe_o));
    rstn_i <= 1'b1;
    wq.delete();
  endtask
  task automatic wait_done;
    for (int n = 0; n < 9000; n++) begin
      @(posedge clk_i);
      #1;
      if (jump_o === 1'b1 || crc_err_o === 1'b1) break;
    end
  endtask
  task automatic chk_out(input int j, input logic [2:0] od,
                         input logic [11:0] f, input int n);
    chk("jump", 32'(j), 32'(jump_o));
    chk("pll", {od, f, 6'h00}, 32'({pll_output_divider_o, pll_feedback_o,
        pll_in_div_o}));
    chk("ram_writes", 32'(n), 32'(wq.size()));
    for (int j = 0; j < n && j < wq.size(); j++) begin
      chk("ram_addr", 32'(j), 32'(wq[j][45:32]));
      chk("ram_data", {img_q[4*j+7], img_q[4*j+6], img_q[4*j+5],
          img_q[4*j+4]}, wq[j][31:0]);
    end
  endtask
  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic t_spi(input int mode);
    mk_img(2, mode);
    foreach (img_q[i]) fl_u.img[i] = img_q[i];
    rst(2'h3, 2'b00, 32'h0);
    wait_done();
    chk("spi_cmd", 32'h0300_0000, fl_u.cmd_q);
    chk("crc_err", 32'(mode == 1), 32'(crc_err_o));
    chk_out(mode != 1, 3'h1, 12'h07A, 2);
  endtask
  task automatic t_link;
    int n;
    logic seen;
    logic [31:0] ack;
    ack = 32'h0000_FF02;
    seen = 1'b0;
    mk_img(1, 0);
    rst(2'h2, 2'b11, 32'h0);
    for (n = 0; n < 2000 && pull_en_o !== 1'b1; n++) @(posedge clk_i);
    for (n = 0; n < 100 && link_oe_o !== 1'b1; n++) @(posedge clk_i);
    chk("link_delay", 32'h1, 32'(n >= 8 && n <= 12));
    for (int i = 0; i < 4 + img_q.size(); i++) begin
      @(posedge clk_i);
      link_byte_vld_i <= 1'b1;
      link_byte_i <= i < 4 ? ack[8*i +: 8] : img_q[i-4];
      @(posedge clk_i);
      link_byte_vld_i <= 1'b0;
    end
    @(posedge clk_i);
    link_end_i <= 1'b1;
    @(posedge clk_i);
    link_end_i <= 1'b0;
    for (n = 0; n < 200; n++) begin
      #1;
      seen = seen | (link_end_o === 1'b1);
      @(posedge clk_i);
    end
    wait_done();
    chk("end_sent", 32'h1, 32'(seen));
    chk("ack_dest", ack, ack_dest_o);
    chk("chanend", 32'h0, 32'(chanend_alloc_o));
    chk_out(1, 3'h2, 12'h077, 1);
  endtask
  task automatic t_otp;
    mk_img(1, 0);
    for (int i = 0; i < 3; i++)
      otp_mem[i] = {img_q[4*i+3], img_q[4*i+2], img_q[4*i+1], img_q[4*i]};
    rst(2'h3, 2'b10, 32'h0000_0020);
    wait_done();
    chk("spi_ss_n", 32'h1, 32'(spi_ss_n_o));
    chk_out(1, 3'h2, 12'h031, 1);
  endtask
  task automatic t_idle(input logic [1:0] src);
    rst(src, 2'b01, 32'h0);
    repeat (1500) @(posedge clk_i);
    #1;
    chk("pull_en", 32'h1, 32'(pull_en_o));
    chk("boot_pins", 32'h0, 32'({spi_oe_o, link_oe_o}));
    chk_out(0, 3'h2, 12'h017, 0);
  endtask
  initial begin
    {rstn_i, pll_strap_low_i, pll_strap_high_i, link_byte_vld_i} = 4'h0;
    {src_strap_i, link_in_i, link_byte_i, link_end_i} = 13'h0000;
    {sec_reg_i, otp_data_i} = 64'h0;
    {fails, compares, cyc} = 96'h0;
    foreach (otp_mem[i]) otp_mem[i] = 32'h0000_0000;
    t_spi(0);
    t_spi(1);
    t_spi(2);
    t_link();
    t_otp();
    t_idle(2'h0);
    t_idle(2'h1);
    complete_run();
  end
endmodule // tb_top
bind bsl_loader bsl_loader_checker chk_u (.*);
`default_nettype wire
